// File: rtl/tcs_bank.sv
// control/status register bank and acquisition sequencing of the tdc
// assumes control-space cycles decoded upstream into one-cycle strobes
// Behaviour
// - reading main register shows maker code on bits 31..16
// - a control-space primary cycle selects the main register
// - logical addressing answered only while bit 1 is set
// - with sparsification on, bit 9 picks simple threshold mode
// - bit 8 primes on advance; multi-block scan without it answers 3
// - commons enable set by reset; gates common start/stop pulses
// - user-space address change (0x80 and up) with commons enabled answers 7
// - memory test mode lets data address be loaded directly
// - writing bit 31 issues a fast clear
// - writing bit 30 restores all registers except subaddress, attach, read data, status and tester counts to reset values
// - advance event steps page by one, loads counter from header
// - writing bit 7 starts one tester burst
// - writing bit 23 acts as a common pulse, always enabled
// - writing bits 29..22 clears latched bits 13..6
// - acquisition bit 31 picks common start, reads back
// - bits 30 and 29 enable rising and falling edges
// - bits 27..24 set clear window after stop or timeout
// - bit 23 enables the internal tester
// - bit 20 enables suppression; off means bit 9 ignored
// - bits 19..18 pick tester width 125, 250, 1000, 2000 ns
// - bits 17..16 pick 1, 2, 4 or 8 pulses at half duty
// - bits 7..4 set start timeout 64 ns to 32768 ns
// - bit 3 accepts line-0 clear; bit 2 accepts line-5 window
// - fast clear discards event, ready again within 300 ns
module tcs_bank
  import tcs_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = 16'h5a5a, // arbitrary value
  parameter int WC_W = 11,
  parameter int NTA_W = 11,
  parameter int PG_W = 3,
  parameter int FCW_CYC = FCW_UNIT_CYC
)
(
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  // control-space access
  input tcs_ctrl_req_s req_i,
  output logic [31:0] rdata_o,
  output logic [2:0] ss_o,
  output logic attached_o,
  input wire logic mdt_scan_i,
  // event buffer side
  input wire logic advance_event_command_i,
  input wire logic [WC_W-1:0] hdr_count_i,
  input wire logic xfer_i,
  input wire logic dsp_nta_wr_i,
  input wire logic [NTA_W-1:0] dsp_nta_i,
  output logic [PG_W-1:0] page_o,
  output logic [WC_W-1:0] block_word_counter_o,
  output logic [NTA_W-1:0] dsp_nta_o,
  output logic memory_test_mode_o,
  // front panel and trigger lines
  input wire logic fp_com_i,
  input wire logic tr_com_i,
  input wire logic fast_clear_input_i,
  input wire logic tr0_clear_i,
  input wire logic tr5_fcw_i,
  input wire logic fp_time_i,
  output logic com_o,
  output logic fast_clear_o,
  output logic fast_clear_window_o,
  output logic acq_ready_o,
  // acquisition configuration out
  output logic common_start_o,
  output logic rise_en_o,
  output logic fall_en_o,
  output logic sparse_en_o,
  output logic sparse_simple_o,
  output logic tester_hit_o
);
  logic [15:0] main_lat;
  tcs_acq_setup_s acq;
  logic [SA_W-1:0] sa;
  logic attached;
  logic acc_wr;
  logic acc_rd;
  logic wr_main;
  logic wr_acq;
  logic mreset;
  logic [15:0] clr_bits;
  logic [15:0] set_bits;
  logic [15:0] next_main;
  tcs_acq_e acq_st;
  tcs_adv_e adv_st;
  logic [21:0] tmr;
  logic [21:0] fcw_cyc;
  logic [12:0] to_cyc;
  logic ext_clr;
  logic timeout_hit;
  logic [7:0] tst_cnt;
  logic [3:0] tst_left;
  logic tst_on;

  assign acc_wr = req_i.wr & attached;
  assign acc_rd = req_i.rd & attached;
  assign wr_main = acc_wr & (sa == SA_MAIN);
  assign wr_acq = acc_wr & (sa == SA_ACQ);
  assign mreset = wr_main & req_i.wdata[B_MRST];

  // upper half clears, lower half sets; a set in the same write wins
  assign set_bits = req_i.wdata[15:0] & MAIN_LATCH_MASK;
  assign clr_bits = req_i.wdata[31:CLR_OFS] & MAIN_LATCH_MASK;
  assign next_main = (main_lat & ~clr_bits) | set_bits;

  // address phase
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      attached <= 1'b0;
      sa <= SA_MAIN;
    end
    else if (clk_en_i)
    begin
      if (req_i.pa)
      begin
        attached <= !req_i.logical || main_lat[B_LA_EN];
        sa <= SA_MAIN;
      end
      else if (req_i.sa_wr && attached)
      begin
        // user space stays locked while commons may fire
        if (!(req_i.sa >= SA_USER && main_lat[B_COMMONS]))
          sa <= req_i.sa;
      end
    end
  end

  // stored registers; command bits are never stored
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      main_lat <= MAIN_RESET;
      acq <= ACQ_RESET;
    end
    else if (clk_en_i)
    begin
      if (mreset)
      begin
        main_lat <= MAIN_RESET;
        acq <= ACQ_RESET;
      end
      else
      begin
        if (wr_main)
          main_lat <= next_main;
        if (wr_acq)
          acq <= req_i.wdata & ACQ_WMASK;
      end
    end
  end

  // read data and slave status
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_o <= '0;
      ss_o <= SS_OK;
    end
    else if (clk_en_i)
    begin
      if (mdt_scan_i && attached && !main_lat[B_PRIME])
        ss_o <= SS_MDT_ERR;
      else if (req_i.sa_wr && attached)
      begin
        if (req_i.sa >= SA_USER && main_lat[B_COMMONS])
          ss_o <= SS_COMMONS;
        else if (req_i.sa > SA_ACQ)
          ss_o <= SS_UNMAPPED;
        else
          ss_o <= SS_OK;
      end
      else if (acc_rd)
      begin
        unique case (sa)
          SA_MAIN:
          begin
            rdata_o <= {MAKER_ID, main_lat};
            ss_o <= SS_OK;
          end
          SA_ACQ:
          begin
            rdata_o <= acq;
            ss_o <= SS_OK;
          end
          default:
          begin
            rdata_o <= '0;
            ss_o <= SS_UNMAPPED;
          end
        endcase
      end
    end
  end

  assign attached_o = attached;
  assign memory_test_mode_o = main_lat[B_MTM];
  assign common_start_o = acq.common_start;
  assign rise_en_o = acq.rise_en;
  assign fall_en_o = acq.fall_en;
  assign sparse_en_o = acq.sparse_en;
  assign sparse_simple_o = acq.sparse_en & main_lat[B_SIMPLE];

  // commons: internal pulse bypasses the enable
  assign com_o = (wr_main & req_i.wdata[B_ICOM])
    | (main_lat[B_COMMONS] & (acq.com_from_tr ? tr_com_i : fp_com_i));
  assign ext_clr = fast_clear_input_i | (acq.tr0_clear_en & tr0_clear_i);
  assign fast_clear_o = (wr_main & req_i.wdata[B_FCLR]) | ext_clr;
  assign fast_clear_window_o = (acq_st == ACQ_FCW)
    | (acq.tr5_fcw_en & tr5_fcw_i);
  assign acq_ready_o = (acq_st == ACQ_IDLE);

  // window and timeout lengths from their codes
  assign fcw_cyc = 22'(FCW_CYC) << acq.fcw_len;
  assign to_cyc = (acq.timeout >= TO_MAX_CODE) ? 13'(TO_MAX_CYC)
    : 13'(TO_MIN_CYC) << (acq.timeout - 4'h1);
  // front-panel timeout still ends the window if the pulse never comes
  assign timeout_hit = (acq.timeout == TO_FRONT)
    ? (fp_time_i || tmr >= 22'(TO_MAX_CYC - 1))
    : (tmr >= 22'(to_cyc) - 22'h1);

  // acquisition sequence
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      acq_st <= ACQ_IDLE;
      tmr <= '0;
    end
    else if (clk_en_i)
    begin
      tmr <= tmr + 22'h1;
      if (mreset)
      begin
        acq_st <= ACQ_IDLE;
        tmr <= '0;
      end
      else if (fast_clear_o && acq_st != ACQ_RECOVER)
      begin
        acq_st <= ACQ_RECOVER;
        tmr <= '0;
      end
      else
      begin
        unique case (acq_st)
          ACQ_IDLE:
            if (com_o)
            begin
              acq_st <= acq.common_start ? ACQ_RUN : ACQ_FCW;
              tmr <= '0;
            end
          ACQ_RUN:
            if (timeout_hit)
            begin
              acq_st <= ACQ_FCW;
              tmr <= '0;
            end
          ACQ_FCW:
            if (tmr >= fcw_cyc - 22'h1)
            begin
              acq_st <= ACQ_IDLE;
              tmr <= '0;
            end
          ACQ_RECOVER:
            if (tmr >= 22'(CLR_RECOVER_CYC - 1))
            begin
              acq_st <= ACQ_IDLE;
              tmr <= '0;
            end
        endcase
      end
    end
  end

  // advance event: step page, then load counter from its header
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      adv_st <= AE_IDLE;
      page_o <= PAGE_RESET;
      block_word_counter_o <= '0;
      dsp_nta_o <= '0;
    end
    else if (clk_en_i)
    begin
      if (mreset)
      begin
        adv_st <= AE_IDLE;
        page_o <= PAGE_RESET;
        block_word_counter_o <= '0;
        dsp_nta_o <= '0;
      end
      else
      begin
        unique case (adv_st)
          AE_IDLE:
          begin
            if (advance_event_command_i)
            begin
              page_o <= page_o + PG_W'(1);
              adv_st <= AE_LOAD;
            end
            else if (xfer_i && block_word_counter_o != '0)
              block_word_counter_o <= block_word_counter_o - WC_W'(1);
            if (dsp_nta_wr_i && main_lat[B_MTM])
              dsp_nta_o <= dsp_nta_i;
          end
          AE_LOAD:
          begin
            adv_st <= AE_IDLE;
            if (main_lat[B_PRIME])
            begin
              block_word_counter_o <= hdr_count_i - WC_W'(1);
              dsp_nta_o <= dsp_nta_o + NTA_W'(1);
            end
            else
              block_word_counter_o <= hdr_count_i;
          end
        endcase
      end
    end
  end

  // internal tester burst, equal high and low times
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tst_on <= 1'b0;
      tester_hit_o <= 1'b0;
      tst_cnt <= '0;
      tst_left <= '0;
    end
    else if (clk_en_i)
    begin
      if (mreset)
      begin
        tst_on <= 1'b0;
        tester_hit_o <= 1'b0;
      end
      else if (!tst_on)
      begin
        if (wr_main && req_i.wdata[B_TEST] && acq.tester_en)
        begin
          tst_on <= 1'b1;
          tester_hit_o <= 1'b1;
          tst_cnt <= TP_CYC[acq.pulse_width] - 8'h1;
          tst_left <= (4'h1 << acq.burst) - 4'h1;
        end
      end
      else if (tst_cnt != '0)
        tst_cnt <= tst_cnt - 8'h1;
      else if (tester_hit_o)
      begin
        tester_hit_o <= 1'b0;
        tst_cnt <= TP_CYC[acq.pulse_width] - 8'h1;
      end
      else if (tst_left != '0)
      begin
        tester_hit_o <= 1'b1;
        tst_left <= tst_left - 4'h1;
        tst_cnt <= TP_CYC[acq.pulse_width] - 8'h1;
      end
      else
        tst_on <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_adv_cmd;
    clk_en_i && advance_event_command_i && adv_st == AE_IDLE && !mreset;
  endsequence
  sequence s_adv_load;
    clk_en_i && !mreset && !main_lat[B_PRIME];
  endsequence

  a_id_read: assert property (clk_en_i && acc_rd && sa == SA_MAIN
    && !mdt_scan_i && !req_i.sa_wr |=> rdata_o[31:16] == MAKER_ID)
    else $error("maker code missing on read");
  a_default_sa: assert property (clk_en_i && req_i.pa
    |=> sa == SA_MAIN)
    else $error("primary cycle did not select main register");
  a_logical_gate: assert property (clk_en_i && req_i.pa
    && req_i.logical && !main_lat[B_LA_EN] |=> !attached_o)
    else $error("logical address answered while disabled");
  a_sparse_sel: assert property (sparse_simple_o
    |-> sparse_en_o && main_lat[B_SIMPLE])
    else $error("simple sparsification without enable");
  a_mdt_refuse: assert property (clk_en_i && mdt_scan_i
    && attached && !main_lat[B_PRIME] |=> ss_o == SS_MDT_ERR)
    else $error("multi-block scan without priming not refused");
  a_commons_lock: assert property (clk_en_i && !mdt_scan_i
    && req_i.sa_wr && attached && req_i.sa >= SA_USER
    && main_lat[B_COMMONS] && !req_i.pa
    |=> ss_o == SS_COMMONS && sa == $past(sa))
    else $error("user space reached with commons enabled");
  a_fclr_cmd: assert property (wr_main && req_i.wdata[B_FCLR]
    && clk_en_i && acq_st != ACQ_RECOVER && !mreset
    |=> acq_st == ACQ_RECOVER && !acq_ready_o)
    else $error("fast clear command ignored");
  a_master_rst: assert property (clk_en_i && mreset
    |=> main_lat == MAIN_RESET && acq == ACQ_RESET
    && page_o == PAGE_RESET && block_word_counter_o == '0)
    else $error("master reset left a register changed");
  a_page_step: assert property (s_adv_cmd ##1 s_adv_load
    |=> page_o == $past(page_o, 2) + PG_W'(1)
    && block_word_counter_o == $past(hdr_count_i))
    else $error("advance event step or load wrong");
  a_no_store: assert property (clk_en_i && wr_main && !mreset
    |=> !main_lat[B_TEST] && !main_lat[14] && !main_lat[15])
    else $error("command bit stored");
endmodule

// File: rtl/tcs_pkg.sv
// constants, field layouts and types of the tdc control/status bank
// assumes a single 125 MHz module clock
package tcs_pkg;
  localparam int CLK_NS = 8;
  localparam int SA_W = 8;
  localparam logic [SA_W-1:0] SA_MAIN = 8'h00;
  localparam logic [SA_W-1:0] SA_ACQ = 8'h01;
  localparam logic [SA_W-1:0] SA_USER = 8'h80;
  // main_control_status bit positions
  localparam int B_LA_EN = 1;
  localparam int B_COMMONS = 2;
  localparam int B_MTM = 6;
  localparam int B_TEST = 7;
  localparam int B_PRIME = 8;
  localparam int B_SIMPLE = 9;
  localparam int B_ICOM = 23;
  localparam int B_MRST = 30;
  localparam int B_FCLR = 31;
  localparam int CLR_OFS = 16;
  localparam logic [15:0] MAIN_LATCH_MASK = 16'h3f46;
  localparam logic [15:0] MAIN_RESET = 16'h0004;
  localparam logic [31:0] ACQ_WMASK = 32'hef9f00ff;
  localparam logic [31:0] ACQ_RESET = 32'h00000000;
  // slave status answers
  localparam logic [2:0] SS_OK = 3'h0;
  localparam logic [2:0] SS_MDT_ERR = 3'h3;
  localparam logic [2:0] SS_UNMAPPED = 3'h6;
  localparam logic [2:0] SS_COMMONS = 3'h7;
  // timing
  localparam int CLR_RECOVER_NS = 300;
  localparam int CLR_RECOVER_CYC = CLR_RECOVER_NS / CLK_NS;
  localparam int TO_MIN_NS = 64;
  localparam int TO_MAX_NS = 32768;
  localparam int TO_MIN_CYC = (TO_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int TO_MAX_CYC = TO_MAX_NS / CLK_NS;
  localparam logic [3:0] TO_MAX_CODE = 4'ha;
  localparam logic [3:0] TO_FRONT = 4'h0;
  localparam int FCW_UNIT_NS = 1000;
  localparam int FCW_UNIT_CYC = (FCW_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int TP_NS0 = 125;
  localparam int TP_NS1 = 250;
  localparam int TP_NS2 = 1000;
  localparam int TP_NS3 = 2000;
  localparam logic [7:0] TP_CYC [4] = '{
    8'((TP_NS0 + CLK_NS - 1) / CLK_NS),
    8'((TP_NS1 + CLK_NS - 1) / CLK_NS),
    8'((TP_NS2 + CLK_NS - 1) / CLK_NS),
    8'((TP_NS3 + CLK_NS - 1) / CLK_NS)};
  localparam logic [2:0] PAGE_RESET = 3'h7;

  typedef struct packed {
    logic common_start;
    logic rise_en;
    logic fall_en;
    logic rsv28;
    logic [3:0] fcw_len;
    logic tester_en;
    logic [1:0] rsv22;
    logic sparse_en;
    logic [1:0] pulse_width;
    logic [1:0] burst;
    logic [7:0] rsv15;
    logic [3:0] timeout;
    logic tr0_clear_en;
    logic tr5_fcw_en;
    logic com_from_tr;
    logic busy_to_tr7;
  } tcs_acq_setup_s;

  typedef struct packed {
    logic pa;
    logic logical;
    logic sa_wr;
    logic [SA_W-1:0] sa;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } tcs_ctrl_req_s;

  typedef enum {ACQ_IDLE, ACQ_RUN, ACQ_FCW, ACQ_RECOVER} tcs_acq_e;
  typedef enum {AE_IDLE, AE_LOAD} tcs_adv_e;
endpackage

// File: verification/tcs_master_model.sv
// control-space master model plus the event header word memory
// assumes the bank samples request strobes on the rising clock edge
module tcs_master_model
  import tcs_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // bank side
  input wire logic [2:0] page_i,
  output tcs_ctrl_req_s req_o,
  output logic [10:0] hdr_count_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // page n holds n+5 words; differs per page so a wrong page shows
  assign hdr_count_o = 11'h005 + {8'h00, page_i};

  initial req_o = '0;

  // one strobe cycle; released data lines are inverted, never left stale
  task automatic cyc(input logic pa, input logic lg, input logic sw,
    input logic [7:0] sa, input logic w, input logic r,
    input logic [31:0] d);
    begin
      @(posedge sys_clk_i);
      req_o <= '{pa, lg, sw, sa, w, r, d};
      @(posedge sys_clk_i);
      req_o <= '{1'b0, 1'b0, 1'b0, sa, 1'b0, 1'b0, ~d};
      #1;
    end
  endtask
endmodule

// File: verification/tcs_bank_tb_top.sv
// self-checking bench for the tdc control/status bank
// assumes the master model drives control space on one 125 MHz clock
module tcs_bank_tb_top
  import tcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] ID = 16'h3c3c; // arbitrary value
  logic sys_clk, resetn, mdt, adv, xfer, nta_wr, fcin, tr5, fpcom, tr0;
  logic [10:0] nta_d, hdr, wc, nta;
  tcs_ctrl_req_s req;
  logic [31:0] rdata;
  logic [2:0] ss, page;
  logic att, memory_test_mode, com, fc, fast_clear_window, rdy, cs, re, fe, sp, sps, hit;
  int num_errors = 0;
  int n_checks = 0;

  tcs_master_model M (.sys_clk_i(sys_clk), .page_i(page), .req_o(req),
    .hdr_count_o(hdr));

  tcs_bank #(.MAKER_ID(ID), .FCW_CYC(2)) DUT (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .clk_en_i(1'b1),
    .req_i(req), .rdata_o(rdata), .ss_o(ss), .attached_o(att),
    .mdt_scan_i(mdt), .advance_event_command_i(adv),
    .hdr_count_i(hdr), .xfer_i(xfer), .dsp_nta_wr_i(nta_wr),
    .dsp_nta_i(nta_d), .page_o(page), .block_word_counter_o(wc),
    .dsp_nta_o(nta), .memory_test_mode_o(memory_test_mode), .fp_com_i(fpcom),
    .tr_com_i(1'b0), .fast_clear_input_i(fcin), .tr0_clear_i(tr0),
    .tr5_fcw_i(tr5), .fp_time_i(1'b0), .com_o(com), .fast_clear_o(fc),
    .fast_clear_window_o(fast_clear_window), .acq_ready_o(rdy), .common_start_o(cs),
    .rise_en_o(re), .fall_en_o(fe), .sparse_en_o(sp),
    .sparse_simple_o(sps), .tester_hit_o(hit));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    begin
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    begin
      n_checks++;
      if (g !== e)
      begin
        num_errors++;
        $display("[ERR] %s exp %h got %h", nm, e, g);
      end
    end
  endtask

  task automatic sel(input logic [7:0] sa);
    M.cyc(1'b0, 1'b0, 1'b1, sa, 1'b0, 1'b0, 32'h0);
  endtask

  task automatic wrr(input logic [7:0] sa, input logic [31:0] d);
    begin
      sel(sa);
      M.cyc(1'b0, 1'b0, 1'b0, sa, 1'b1, 1'b0, d);
    end
  endtask

  task automatic rdr(input logic [7:0] sa, output logic [31:0] d);
    begin
      sel(sa);
      M.cyc(1'b0, 1'b0, 1'b0, sa, 1'b0, 1'b1, 32'h0);
      d = rdata;
    end
  endtask

  // k: 0 advance, 1 transfer, 2 scan, 3 clear, 4 common
  task automatic pul(input int k);
    begin
      @(posedge sys_clk);
      {fpcom, fcin, mdt, xfer, adv} <= 5'h1 << k;
      @(posedge sys_clk);
      {fpcom, fcin, mdt, xfer, adv} <= 5'h0;
      #1;
    end
  endtask

  task automatic wait_rdy(input int lim);
    int n;
    begin
      n = 0;
      while (rdy !== 1'b1 && n < lim)
      begin
        @(posedge sys_clk);
        #1 n++;
      end
      chk("acq_ready", 1, rdy);
    end
  endtask

  task automatic ldnta();
    begin
      @(posedge sys_clk);
      nta_wr <= 1'b1;
      @(posedge sys_clk);
      nta_wr <= 1'b0;
      #1;
    end
  endtask

  task automatic t_addr();
    begin
      M.cyc(1, 1, 0, 0, 0, 0, 0);
      chk("attach_logical_off", 0, att);
      M.cyc(1, 0, 0, 0, 0, 0, 0);
      M.cyc(0, 0, 0, 0, 0, 1, 0);
      chk("main_default", {ID, 16'h0004}, rdata);
      chk("page_reset", 7, page);
      wrr(0, 32'h0000_0002);
      M.cyc(1, 1, 0, 0, 0, 0, 0);
      chk("attach_logical_on", 1, att);
    end
  endtask

  task automatic t_acq();
    logic [31:0] d;
    begin
      wrr(1, 32'hffff_ffff);
      rdr(1, d);
      chk("acq_rb", ACQ_WMASK, d);
      chk("acq_out", 4'hf, {cs, re, fe, sp});
      wrr(1, 32'h0000_000c);
      @(posedge sys_clk);
      tr5 <= 1'b1;
      tr0 <= 1'b1;
      #1 chk("fcw_ext", 1, fast_clear_window);
      chk("clr_tr0", 1, fc);
      // dropped before the next edge so no clear sequence starts
      tr0 <= 1'b0;
      wrr(1, 0);
      chk("fcw_ext_off", 0, fast_clear_window);
      tr5 <= 1'b0;
      rdr(1, d);
      chk("acq_zero", 0, d);
    end
  endtask

  task automatic t_main();
    logic [31:0] d;
    begin
      wrr(0, 32'h0000_ff7f);
      rdr(0, d);
      chk("main_set", {ID, 16'h3f46}, d);
      chk("simple_off", 0, sps);
      wrr(1, 32'h0010_0000);
      chk("simple_on", 1, sps);
      wrr(1, 0);
      wrr(0, 32'h3fc0_0000);
      chk("int_com", 0, rdy);
      rdr(0, d);
      chk("main_clr", {ID, 16'h0006}, d);
      wait_rdy(20);
    end
  endtask

  task automatic t_clear();
    logic [31:0] d;
    begin
      wrr(0, 32'h8000_0000);
      chk("clr_cmd", 0, rdy);
      wait_rdy(CLR_RECOVER_CYC);
      rdr(0, d);
      chk("clr_keeps", {ID, 16'h0006}, d);
      @(posedge sys_clk);
      fcin <= 1'b1;
      #1 chk("clr_in", 1, fc);
      @(posedge sys_clk);
      fcin <= 1'b0;
      #1 chk("clr_in_busy", 0, rdy);
      wait_rdy(CLR_RECOVER_CYC);
    end
  endtask

  task automatic t_ss();
    begin
      sel(8'h80);
      chk("ss_lock", 3'h7, ss);
      sel(8'h02);
      chk("ss_unmapped", 3'h6, ss);
      @(posedge sys_clk);
      fpcom <= 1'b1;
      #1 chk("com_fp", 1, com);
      fpcom <= 1'b0;
      pul(4);
      chk("com_on", 0, rdy);
      chk("fcw_win", 1, fast_clear_window);
      wait_rdy(20);
      wrr(0, 32'h0004_0000);
      sel(8'h80);
      // commons now disabled, so no lock; user space is not mapped in this bank, so unmapped
      chk("ss_user", SS_UNMAPPED, ss);
      pul(4);
      chk("com_off", 1, rdy);
    end
  endtask

  task automatic t_adv();
    begin
      pul(2);
      chk("mdt_noprime", 3'h3, ss);
      nta_d <= 11'h123;
      ldnta();
      chk("nta_locked", 0, nta);
      pul(0);
      chk("page_step", 0, page);
      @(posedge sys_clk);
      #1 chk("wc_load", 5, wc);
      pul(1);
      chk("wc_dec", 4, wc);
      wrr(0, 32'h0000_0140);
      chk("mtm_out", 1, memory_test_mode);
      ldnta();
      chk("nta_mtm", 11'h123, nta);
      pul(0);
      @(posedge sys_clk);
      #1 chk("wc_prime", 5, wc);
      chk("nta_prime", 11'h124, nta);
      pul(2);
      chk("mdt_prime", 3'h0, ss);
    end
  endtask

  // common start: hits taken until the timeout, then the clear window
  task automatic t_start();
    int n;
    begin
      wrr(0, 32'h0000_0004);
      wrr(1, 32'h8000_0010);
      chk("start_mode", 1, cs);
      pul(4);
      chk("start_run", 0, rdy);
      chk("start_fcw_off", 0, fast_clear_window);
      n = 0;
      while (rdy !== 1'b1 && n < 40)
      begin
        @(posedge sys_clk);
        #1 n++;
      end
      // 64 ns timeout, then the two-cycle window set at the instance
      chk("start_span", TO_MIN_CYC + 2, n);
    end
  endtask

  task automatic t_mrst();
    logic [31:0] d;
    begin
      wrr(1, 32'h8000_00f0);
      wrr(0, 32'h4000_0000);
      rdr(0, d);
      chk("mrst_main", {ID, 16'h0004}, d);
      rdr(1, d);
      chk("mrst_acq", 0, d);
      chk("mrst_page", 7, page);
      chk("mrst_wc", 0, wc);
    end
  endtask

  // counts high cycles and rising edges of the tester output
  task automatic t_tester();
    int hi, ups, exp_hi;
    logic prev;
    begin
      for (int c = -1; c < 4; c++)
      begin
        exp_hi = (c < 0) ? 0 : (1 << c) * TP_CYC[c];
        wrr(1, (c < 0) ? 32'h0 : 32'h0080_0000 | (c << 18) | (c << 16));
        wrr(0, 32'h0000_0084);
        hi = 0;
        ups = 0;
        prev = 1'b0;
        // first sample is taken now: the output rises with the write
        repeat (2 * exp_hi + 20)
        begin
          hi += (hit === 1'b1);
          ups += (hit === 1'b1 && !prev);
          prev = hit;
          @(posedge sys_clk);
          #1;
        end
        chk("tst_high", exp_hi, hi);
        chk("tst_pulses", (c < 0) ? 0 : 1 << c, ups);
      end
    end
  endtask

  initial
  begin
    resetn = 1'b0;
    {mdt, adv, xfer, nta_wr, fcin, tr5, fpcom, tr0} = '0;
    nta_d = '0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    t_addr();
    t_acq();
    t_main();
    t_clear();
    t_ss();
    t_adv();
    t_start();
    t_mrst();
    t_tester();
    finish_test();
  end

  // whole run is near 5.5k cycles; over three times that means a hang
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    finish_test();
  end
endmodule
